// ### hdl/dual_interval_timer_pkg.sv
// Purpose: Constants for the dual interval timer with toggle outputs
// Assumes: 32-bit AXI4-Lite, one word per register, byte address = 4 * index
// Notes: Indices are kept as printed; the byte address is derived from each

package dual_interval_timer_pkg;

  // ----------------------------------------
  // Bus geometry
  // ----------------------------------------
  localparam int ADDR_W = 20;
  localparam int DATA_W = 32;
  localparam int NUM_TIMERS = 2;

  // ----------------------------------------
  // Register indices and byte addresses
  // ----------------------------------------
  localparam logic [15:0] IDX_PORT_FN = 16'hfe4f;
  localparam logic [15:0] IDX_CTRL = 16'hfe78;
  localparam logic [15:0] IDX_PERIOD0 = 16'hfe7a;
  localparam logic [15:0] IDX_PERIOD1 = 16'hfe7b;
  localparam logic [15:0] IDX_EVT_STATUS = 16'hfe80;
  localparam logic [15:0] IDX_EVT_MASK = 16'hfe81;
  localparam logic [15:0] IDX_PIN_CTL = 16'hfe82;

  localparam logic [ADDR_W-1:0] ADDR_PORT_FN = {2'h0, IDX_PORT_FN, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_CTRL = {2'h0, IDX_CTRL, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_PERIOD0 = {2'h0, IDX_PERIOD0, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_PERIOD1 = {2'h0, IDX_PERIOD1, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_EVT_STATUS = {2'h0, IDX_EVT_STATUS, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_EVT_MASK = {2'h0, IDX_EVT_MASK, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_PIN_CTL = {2'h0, IDX_PIN_CTL, 2'h0};

  // ----------------------------------------
  // Field positions (timer i adds 2*i in ctrl, i in port_fn and pin_ctl)
  // ----------------------------------------
  localparam int IE_BIT = 0;
  localparam int OV_BIT = 1;
  localparam int CS_LSB = 4;
  localparam int TOG_EN_LSB = 6;
  localparam int LATCH_LSB = 0;
  localparam int DIR_LSB = 2;

  // ----------------------------------------
  // Reset values and encodings
  // ----------------------------------------
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [1:0] CS_STOP = 2'h0;
  localparam logic [1:0] CS_DIV4 = 2'h1;
  localparam logic [1:0] CS_DIV16 = 2'h2;
  localparam logic [1:0] CS_DIV64 = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ### hdl/dual_interval_timer_toggle.sv
// Purpose: Two 8-bit interval timers with prescalers, flags and pin toggles
// Assumes: AXI4-Lite slave, 100 MHz aclk, synchronous active-low reset
// Notes: Only the low byte of each register word is used
//
// Register access over AXI4-Lite was left to the implementer.

`timescale 1ns/10ps

// How it works
// - First clock select 00 holds timer reset; 01/10/11 count per 4/16/64 clocks.
// - Second clock select uses the same encoding in bits 6 and 7.
// - First counter steps on prescaler ticks, wraps after matching period, sets flag.
// - Second counter steps on its ticks, wraps after matching period, sets flag.
// - First counter sits at zero while its select is 00, otherwise counts.
// - Second counter sits at zero while its select is 00, otherwise counts.
// - Writing first period while running clears prescaler and counter.
// - Writing second period while running clears prescaler and counter.
// - First period is (period value + 1) times 4, 16 or 64 clocks.
// - Second period is (period value + 1) times 4, 16 or 64 clocks.
// - First overflow flag set each period by hardware, cleared only by software.
// - Second overflow flag set each period by hardware, cleared only by software.
// - First enable and first flag both high request the shared timer interrupt.
// - Second enable and second flag both high request the shared timer interrupt.
// - First pin in output mode drives latch, or latch OR toggle when enabled.
// - Second pin in output mode drives latch, or latch OR toggle when enabled.
module dual_interval_timer_toggle (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write address channel
  input wire logic awvalid,
  output logic awready,
  input wire logic [dual_interval_timer_pkg::ADDR_W-1:0] awaddr,
  // Write data channel
  input wire logic wvalid,
  output logic wready,
  input wire logic [dual_interval_timer_pkg::DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  // Write response channel
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // Read address channel
  input wire logic arvalid,
  output logic arready,
  input wire logic [dual_interval_timer_pkg::ADDR_W-1:0] araddr,
  // Read data channel
  output logic rvalid,
  input wire logic rready,
  output logic [dual_interval_timer_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  // First toggle pin
  input wire logic first_toggle_pin_in,
  output logic first_toggle_pin_out,
  output logic first_toggle_pin_oe,
  // Second toggle pin
  input wire logic second_toggle_pin_in,
  output logic second_toggle_pin_out,
  output logic second_toggle_pin_oe,
  // Interrupts
  output logic timer_irq,
  output logic event_irq
);
  import dual_interval_timer_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] ctrl;
    logic [NUM_TIMERS-1:0][7:0] period;
    logic [7:0] port_fn;
    logic [3:0] pin_ctl;
    logic [NUM_TIMERS-1:0][5:0] pre;
    logic [NUM_TIMERS-1:0][7:0] cnt;
    logic [NUM_TIMERS-1:0] tog;
    logic [NUM_TIMERS-1:0] evt_status;
    logic [NUM_TIMERS-1:0] evt_mask;
    logic timer_irq;
    logic event_irq;
    logic [NUM_TIMERS-1:0] pin_out;
    logic [NUM_TIMERS-1:0] pin_oe;
    logic [NUM_TIMERS-1:0] pin_meta;
    logic [NUM_TIMERS-1:0] pin_sync;
    logic aw_held;
    logic w_held;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic [ADDR_W-1:0] waddr;
    logic [7:0] wbyte;
    logic wlane;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [7:0] rbyte;
  } state_t;

  localparam state_t STATE_RESET = '0;

  state_t q;
  state_t d;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [1:0] sel_of(logic [7:0] ctrl, int i);
    return ctrl[CS_LSB+2*i +: 2];
  endfunction

  function automatic logic pre_tick(logic [1:0] cs, logic [5:0] pre);
    logic t;
    t = 1'b0;
    case (cs)
      CS_DIV4: t = &pre[1:0];
      CS_DIV16: t = &pre[3:0];
      CS_DIV64: t = &pre[5:0];
      default: t = 1'b0;
    endcase
    return t;
  endfunction

  function automatic logic mapped(logic [ADDR_W-1:0] a);
    return a == ADDR_PORT_FN || a == ADDR_CTRL || a == ADDR_PERIOD0 ||
      a == ADDR_PERIOD1 || a == ADDR_EVT_STATUS || a == ADDR_EVT_MASK ||
      a == ADDR_PIN_CTL;
  endfunction

  logic wr_fire;
  logic wr_en;
  logic rd_fire;
  logic ctrl_wr;
  logic [NUM_TIMERS-1:0] period_wr;
  logic [NUM_TIMERS-1:0] running;
  logic [NUM_TIMERS-1:0] tick;
  logic [NUM_TIMERS-1:0] wrap_ev;

  assign wr_fire = q.aw_held && q.w_held && !q.bvalid;
  assign wr_en = wr_fire && q.wlane;
  assign rd_fire = arvalid && q.arready;
  assign ctrl_wr = wr_en && q.waddr == ADDR_CTRL;
  assign period_wr[0] = wr_en && q.waddr == ADDR_PERIOD0;
  assign period_wr[1] = wr_en && q.waddr == ADDR_PERIOD1;

  always_comb begin
    for (int i = 0; i < NUM_TIMERS; i++) begin
      running[i] = sel_of(q.ctrl, i) != CS_STOP;
      tick[i] = pre_tick(sel_of(q.ctrl, i), q.pre[i]);
      wrap_ev[i] = running[i] && !period_wr[i] && tick[i] &&
        q.cnt[i] == q.period[i];
    end
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    d = q;

    // Write channels, taken in either order
    if (awvalid && q.awready) begin
      d.aw_held = 1'b1;
      d.waddr = awaddr;
    end
    if (wvalid && q.wready) begin
      d.w_held = 1'b1;
      d.wbyte = wdata[7:0];
      d.wlane = wstrb[0];
    end
    if (q.bvalid && bready) begin
      d.bvalid = 1'b0;
      d.aw_held = 1'b0;
      d.w_held = 1'b0;
    end
    if (wr_fire) begin
      d.bvalid = 1'b1;
      d.bresp = mapped(q.waddr) ? RESP_OKAY : RESP_SLVERR;
    end

    // Plain register writes
    if (wr_en && q.waddr == ADDR_PORT_FN) begin
      d.port_fn = q.wbyte;
    end
    if (wr_en && q.waddr == ADDR_EVT_MASK) begin
      d.evt_mask = q.wbyte[NUM_TIMERS-1:0];
    end
    if (wr_en && q.waddr == ADDR_PIN_CTL) begin
      d.pin_ctl = q.wbyte[3:0];
    end
    if (ctrl_wr) begin
      d.ctrl = q.wbyte;
    end

    // Timers
    for (int i = 0; i < NUM_TIMERS; i++) begin
      if (period_wr[i]) begin
        d.period[i] = q.wbyte;
      end
      if (!running[i]) begin
        d.pre[i] = '0;
        d.cnt[i] = '0;
        d.tog[i] = 1'b0;
      end else if (period_wr[i]) begin
        d.pre[i] = '0;
        d.cnt[i] = '0;
      end else begin
        d.pre[i] = 6'(q.pre[i] + 6'h01);
        if (wrap_ev[i]) begin
          d.cnt[i] = '0;
          d.tog[i] = !q.tog[i];
        end else if (tick[i]) begin
          d.cnt[i] = 8'(q.cnt[i] + 8'h01);
        end
      end
      // Hardware set wins over a clearing write
      d.ctrl[OV_BIT+2*i] = d.ctrl[OV_BIT+2*i] | wrap_ev[i];
    end

    // Event status, cleared by reading it
    if (rd_fire && araddr == ADDR_EVT_STATUS) begin
      d.evt_status = '0;
    end
    d.evt_status = d.evt_status | wrap_ev;

    // Read channel
    if (q.rvalid && rready) begin
      d.rvalid = 1'b0;
    end
    if (rd_fire) begin
      d.rvalid = 1'b1;
      d.rresp = mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      case (araddr)
        ADDR_PORT_FN: d.rbyte = q.port_fn;
        ADDR_CTRL: d.rbyte = q.ctrl;
        ADDR_PERIOD0: d.rbyte = q.period[0];
        ADDR_PERIOD1: d.rbyte = q.period[1];
        ADDR_EVT_STATUS: d.rbyte = {6'h00, q.evt_status};
        ADDR_EVT_MASK: d.rbyte = {6'h00, q.evt_mask};
        ADDR_PIN_CTL: d.rbyte = {2'h0, q.pin_sync, q.pin_ctl};
        default: d.rbyte = REG_RESET;
      endcase
    end

    // Ready flags
    d.awready = !d.aw_held && !d.bvalid;
    d.wready = !d.w_held && !d.bvalid;
    d.arready = !d.rvalid;

    // Interrupts
    d.timer_irq = (d.ctrl[IE_BIT] && d.ctrl[OV_BIT]) ||
      (d.ctrl[IE_BIT+2] && d.ctrl[OV_BIT+2]);
    d.event_irq = |(d.evt_status & d.evt_mask);

    // Pins
    d.pin_meta = {second_toggle_pin_in, first_toggle_pin_in};
    d.pin_sync = q.pin_meta;
    for (int i = 0; i < NUM_TIMERS; i++) begin
      d.pin_oe[i] = d.pin_ctl[DIR_LSB+i];
      d.pin_out[i] = d.pin_ctl[LATCH_LSB+i] |
        (d.port_fn[TOG_EN_LSB+i] & d.tog[i]);
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= STATE_RESET;
    end else begin
      q <= d;
    end
  end

  assign awready = q.awready;
  assign wready = q.wready;
  assign bvalid = q.bvalid;
  assign bresp = q.bresp;
  assign arready = q.arready;
  assign rvalid = q.rvalid;
  assign rresp = q.rresp;
  assign rdata = {24'h000000, q.rbyte};
  assign first_toggle_pin_out = q.pin_out[0];
  assign first_toggle_pin_oe = q.pin_oe[0];
  assign second_toggle_pin_out = q.pin_out[1];
  assign second_toggle_pin_oe = q.pin_oe[1];
  assign timer_irq = q.timer_irq;
  assign event_irq = q.event_irq;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  chk_first_stop_hold: assert property (
    !running[0] |=> q.cnt[0] == 8'h00 && q.pre[0] == 6'h00 && !q.tog[0])
    else $error("first timer not held while stopped");

  chk_second_stop_hold: assert property (
    !running[1] |=> q.cnt[1] == 8'h00 && q.pre[1] == 6'h00 && !q.tog[1])
    else $error("second timer not held while stopped");

  chk_first_wrap_flag: assert property (
    running[0] && !period_wr[0] && tick[0] && q.cnt[0] == q.period[0]
    |=> q.cnt[0] == 8'h00 && q.ctrl[OV_BIT] && q.tog[0] != $past(q.tog[0]))
    else $error("first timer wrap missing");

  chk_second_wrap_flag: assert property (
    running[1] && !period_wr[1] && tick[1] && q.cnt[1] == q.period[1]
    |=> q.cnt[1] == 8'h00 && q.ctrl[OV_BIT+2])
    else $error("second timer wrap missing");

  chk_first_count_step: assert property (
    running[0] && !period_wr[0] && tick[0] && q.cnt[0] != q.period[0]
    |=> q.cnt[0] == 8'($past(q.cnt[0]) + 8'h01))
    else $error("first counter did not step");

  chk_second_idle_run: assert property (
    running[1] && !period_wr[1] && !tick[1] |=> $stable(q.cnt[1]))
    else $error("second counter moved without tick");

  chk_first_period_restart: assert property (
    running[0] && period_wr[0] |=> q.cnt[0] == 8'h00 && q.pre[0] == 6'h00)
    else $error("first period write did not restart");

  chk_second_period_restart: assert property (
    running[1] && period_wr[1] |=> q.cnt[1] == 8'h00 && q.pre[1] == 6'h00)
    else $error("second period write did not restart");

  chk_first_div4_tick: assert property (
    sel_of(q.ctrl, 0) == CS_DIV4 && !period_wr[0] && tick[0]
    ##1 sel_of(q.ctrl, 0) == CS_DIV4 && !period_wr[0]
    |-> !tick[0] ##1 !tick[0] ##1 !tick[0])
    else $error("first prescale by four wrong");

  chk_second_pre_step: assert property (
    running[1] && !period_wr[1]
    |=> q.pre[1] == 6'($past(q.pre[1]) + 6'h01))
    else $error("second prescaler did not step");

  chk_first_flag_sticky: assert property (
    q.ctrl[OV_BIT] && !ctrl_wr |=> q.ctrl[OV_BIT])
    else $error("first flag lost");

  chk_second_flag_sticky: assert property (
    q.ctrl[OV_BIT+2] && !ctrl_wr |=> q.ctrl[OV_BIT+2])
    else $error("second flag lost");

  chk_timer_irq_level: assert property (
    timer_irq == ((q.ctrl[IE_BIT] && q.ctrl[OV_BIT]) ||
    (q.ctrl[IE_BIT+2] && q.ctrl[OV_BIT+2])))
    else $error("timer request disagrees with flags");

  chk_second_irq_raise: assert property (
    $rose(q.ctrl[OV_BIT+2]) && q.ctrl[IE_BIT+2] |-> timer_irq)
    else $error("second flag did not request");

  chk_first_pin_drive: assert property (
    first_toggle_pin_oe && !q.port_fn[TOG_EN_LSB]
    |-> first_toggle_pin_out == q.pin_ctl[LATCH_LSB])
    else $error("first pin not latch");

  chk_second_pin_drive: assert property (
    second_toggle_pin_oe && q.port_fn[TOG_EN_LSB+1] && q.tog[1]
    |-> second_toggle_pin_out)
    else $error("second pin missing toggle");

  chk_irq_hold: assert property (
    timer_irq && !ctrl_wr |=> timer_irq)
    else $error("timer request dropped");

  cov_first_wrap: cover property (wrap_ev[0]);
  cov_both_wrap: cover property (wrap_ev[0] && wrap_ev[1]);
  cov_irq_rise: cover property ($rose(timer_irq));
  cov_restart: cover property (running[0] && period_wr[0]);

endmodule // dual_interval_timer_toggle

// ### testbench/dual_interval_timer_toggle_tb.sv
// Purpose: Self-checking bench for the dual interval timer with toggle outputs
// Assumes: 100 MHz aclk, synchronous active-low reset, AXI4-Lite register access
// Notes: Periods are measured on the toggle pins in clock cycles

`timescale 1ns/10ps

module dual_interval_timer_toggle_tb;
  import dual_interval_timer_pkg::*;

  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, timer_irq, event_irq;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [DATA_W-1:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, pin_in, pin_out, pin_oe, last_bresp;
  int err_count, n_compared, cycles;

  dual_interval_timer_toggle i_dual_interval_timer_toggle (
    .aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .first_toggle_pin_in(pin_in[0]), .first_toggle_pin_out(pin_out[0]), .first_toggle_pin_oe(pin_oe[0]),
    .second_toggle_pin_in(pin_in[1]), .second_toggle_pin_out(pin_out[1]), .second_toggle_pin_oe(pin_oe[1]),
    .timer_irq(timer_irq), .event_irq(event_irq)
  );

  // ----------------------------------------
  // Clock, timeout and report
  // ----------------------------------------
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    cycles++;
    if (cycles == 60000) begin
      err_count++;
      conclude();
    end
  end

  task automatic conclude();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  // ----------------------------------------
  // Bus and pin helpers
  // ----------------------------------------
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    logic ah, wh, ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ad && wd)) begin
      @(negedge aclk);
      ah = awvalid && awready;
      wh = wvalid && wready;
      @(posedge aclk);
      if (ah) begin
        awvalid <= 1'b0;
        ad = 1'b1;
      end
      if (wh) begin
        wvalid <= 1'b0;
        wd = 1'b1;
      end
    end
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      ah = bvalid;
      last_bresp = bresp;
      @(posedge aclk);
    end while (!ah);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
    logic h;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(negedge aclk);
      h = arready;
      @(posedge aclk);
    end while (!h);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do begin
      @(negedge aclk);
      h = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
    end while (!h);
    rready <= 1'b0;
  endtask

  // Counts negedges until toggle pin t changes
  task automatic chg(input int t, output int n);
    logic v;
    v = pin_out[t];
    n = 0;
    while (pin_out[t] === v && n < 3000) begin
      @(negedge aclk);
      n++;
    end
  endtask

  task automatic meas(input int t, output int n);
    @(negedge aclk);
    chg(t, n);
    chg(t, n);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_reset();
    logic [31:0] d;
    logic [1:0] r;
    logic [ADDR_W-1:0] regs [4] = '{ADDR_CTRL, ADDR_PERIOD0, ADDR_PERIOD1, ADDR_PORT_FN};
    foreach (regs[i]) begin
      rd(regs[i], d, r);
      check("reset value", d, 32'h0);
      check("read response", r, RESP_OKAY);
    end
    @(negedge aclk);
    check("idle pins", {pin_out, pin_oe, timer_irq}, 32'h0);
    rd(20'h00040, d, r);
    check("unmapped response", r, RESP_SLVERR);
    wr(20'h00040, 8'h00);
    check("unmapped write response", last_bresp, RESP_SLVERR);
  endtask

  task automatic test_prescale(input int t);
    int n;
    wr(ADDR_PIN_CTL, 8'h0c);
    check("write response", last_bresp, RESP_OKAY);
    wr(ADDR_PORT_FN, 8'hc0);
    wr(t ? ADDR_PERIOD1 : ADDR_PERIOD0, 8'h02);
    for (int s = 1; s < 4; s++) begin
      wr(ADDR_CTRL, 8'(s << (CS_LSB + 2 * t)));
      meas(t, n);
      check("toggle period", n, 3 * (4 ** s));
    end
    wr(t ? ADDR_PERIOD1 : ADDR_PERIOD0, 8'hff);
    wr(ADDR_CTRL, 8'(CS_DIV4) << (CS_LSB + 2 * t));
    meas(t, n);
    check("longest period", n, 32'd1024);
  endtask

  task automatic test_stop();
    wr(ADDR_CTRL, 8'h00);
    repeat (3) begin
      repeat (70) @(negedge aclk);
      check("stopped pins", pin_out, 2'b00);
    end
  endtask

  task automatic test_irq();
    logic [31:0] d;
    logic [1:0] r;
    check("masked event", event_irq, 1'b0);
    rd(ADDR_EVT_STATUS, d, r);
    wr(ADDR_PERIOD0, 8'h00);
    wr(ADDR_PERIOD1, 8'h00);
    wr(ADDR_EVT_MASK, 8'h03);
    for (int t = 0; t < 2; t++) begin
      wr(ADDR_CTRL, 8'(1 << (2 * t)));
      repeat (2) @(negedge aclk);
      check("irq before overflow", timer_irq, 1'b0);
      wr(ADDR_CTRL, 8'((1 << (2 * t)) | (CS_DIV4 << (CS_LSB + 2 * t))));
      repeat (8) @(negedge aclk);
      check("irq on overflow", {timer_irq, event_irq}, 2'b11);
      repeat (40) @(negedge aclk);
      rd(ADDR_CTRL, d, r);
      check("flag set", d, 32'((3 << (2 * t)) | (CS_DIV4 << (CS_LSB + 2 * t))));
      wr(ADDR_CTRL, 8'(3 << (2 * t)));
      repeat (40) @(negedge aclk);
      rd(ADDR_CTRL, d, r);
      check("flag held", d, 32'(3 << (2 * t)));
      rd(ADDR_EVT_STATUS, d, r);
      check("event status", d, 32'(1 << t));
      repeat (2) @(negedge aclk);
      check("event irq cleared", event_irq, 1'b0);
      wr(ADDR_CTRL, 8'(1 << (2 * t)));
      repeat (2) @(negedge aclk);
      check("irq after clear", timer_irq, 1'b0);
    end
  endtask

  task automatic test_restart(input int t);
    int n;
    logic [31:0] d;
    logic [1:0] r;
    wr(ADDR_CTRL, 8'(CS_DIV64) << (CS_LSB + 2 * t));
    wr(t ? ADDR_PERIOD1 : ADDR_PERIOD0, 8'h03);
    rd(t ? ADDR_PERIOD1 : ADDR_PERIOD0, d, r);
    check("period readback", d, 32'h03);
    meas(t, n);
    check("restart period", n, 32'd256);
    repeat (100) @(negedge aclk);
    wr(t ? ADDR_PERIOD1 : ADDR_PERIOD0, 8'h03);
    @(negedge aclk);
    chg(t, n);
    // Full period counted from the write, less the cycles the write took
    check("restart delay", n, 32'd255);
  endtask

  task automatic test_pins();
    logic [31:0] d;
    logic [1:0] r;
    logic bad;
    logic [1:0] seen1;
    bad = 1'b0;
    seen1 = 2'b00;
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_PORT_FN, 8'h00);
    pin_in <= 2'b10;
    wr(ADDR_PIN_CTL, 8'h0d);
    repeat (2) @(negedge aclk);
    check("latch drive", {pin_oe, pin_out}, 4'b1101);
    wr(ADDR_PORT_FN, 8'hc0);
    wr(ADDR_CTRL, 8'h50);
    repeat (60) begin
      @(negedge aclk);
      if (pin_out[0] !== 1'b1) begin
        bad = 1'b1;
      end
      if (pin_out[1] === 1'b1) begin
        seen1[1] = 1'b1;
      end
      if (pin_out[1] === 1'b0) begin
        seen1[0] = 1'b1;
      end
    end
    check("latch or toggle", bad, 1'b0);
    check("second latch or toggle", seen1, 2'b11);
    wr(ADDR_PIN_CTL, 8'h00);
    repeat (2) @(negedge aclk);
    check("input mode", pin_oe, 2'b00);
    rd(ADDR_PIN_CTL, d, r);
    check("synced inputs", d[5:4], 2'b10);
  endtask

  task automatic test_midreset();
    logic [31:0] d;
    logic [1:0] r;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    check("outputs after reset", {timer_irq, event_irq, pin_out, pin_oe, awready, arready}, 32'h0);
    rd(ADDR_CTRL, d, r);
    check("control after reset", d, 32'h0);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    err_count = 0;
    n_compared = 0;
    cycles = 0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'h0;
    pin_in = 2'b00;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    test_reset();
    test_prescale(0);
    test_prescale(1);
    test_stop();
    test_irq();
    test_restart(0);
    test_restart(1);
    test_pins();
    test_midreset();
    conclude();
  end
endmodule // dual_interval_timer_toggle_tb
